/* pkg/orx_consts.vh */
// constants for the or/return/rotate execution slice
// assumes includer owns clk and synchronous active-high rst
// Operation
// - nop changes nothing, only advances
// - or memory into accumulator, zero only
// - or immediate into accumulator, zero only
// - or accumulator into memory, zero only
// - return pops stack into pc, no flags
// - return pops pc, loads immediate into accumulator
// - interrupt return pops pc, sets enable
// - pending interrupt served before main resumes
// - rotate memory left, bit7 to bit0, no flags
`ifndef ORX_CONSTS_VH
`define ORX_CONSTS_VH
`define ORX_OP_W 4
`define ORX_OP_NOP 4'h0
`define ORX_OP_OR_MEM 4'h1
`define ORX_OP_OR_IMM 4'h2
`define ORX_OP_OR_INTO_MEM 4'h3
`define ORX_OP_RET 4'h4
`define ORX_OP_RET_VAL 4'h5
`define ORX_OP_INT_RETURN 4'h6
`define ORX_OP_ROT_LEFT_MEM 4'h7
`define ORX_PC_W 13
`define ORX_ADDR_W 8
`define ORX_DATA_W 8
`define ORX_STACK_DEPTH 8
`define ORX_SP_W 3
`define ORX_ACC_RST 8'h00
`define ORX_PC_RST 13'h0000
`define ORX_INT_VECTOR 13'h0004
`endif

/* logic/orx_alu.v */
// combinational result unit for or and rotate-left
// assumes operands arrive stable from the sequencer
`timescale 1ns/10ps
`include "orx_consts.vh"
module orx_alu (
  // operands
  input wire [`ORX_DATA_W-1:0] a,
  input wire [`ORX_DATA_W-1:0] b,
  input wire rotate,
  // result
  output wire [`ORX_DATA_W-1:0] y,
  output wire zero
);
  assign y = rotate ? {b[`ORX_DATA_W-2:0], b[`ORX_DATA_W-1]} : (a | b);
  assign zero = (y == 8'h00);
endmodule // orx_alu

/* logic/orx_exec.v */
// executes nop, or forms, returns and rotate-left of memory
// assumes a one-cycle synchronous data memory read port and an external instruction source
`timescale 1ns/10ps
`include "orx_consts.vh"
module orx_exec (
  // clock and reset
  input wire clk,
  input wire rst,
  // instruction issue
  input wire instr_valid,
  input wire [`ORX_OP_W-1:0] instr_op,
  input wire [`ORX_ADDR_W-1:0] instr_addr,
  input wire [`ORX_DATA_W-1:0] instr_imm,
  output wire instr_ready,
  // subroutine entry, pushes the return address
  input wire call_valid,
  input wire [`ORX_PC_W-1:0] call_target,
  // interrupt request from the controller, same clock
  input wire int_pending,
  // data memory
  output reg mem_rd_q,
  output reg mem_wr_q,
  output reg [`ORX_ADDR_W-1:0] mem_addr_q,
  output reg [`ORX_DATA_W-1:0] mem_wdata_q,
  input wire [`ORX_DATA_W-1:0] mem_rdata,
  // architectural state
  output reg [`ORX_DATA_W-1:0] accumulator_q,
  output reg zero_flag_q,
  output reg master_interrupt_enable_q,
  output reg [`ORX_PC_W-1:0] pc_q,
  output reg int_taken_q
);
  // one-hot states; the wait state covers the memory's read latency
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WAIT = 4'h2;
  localparam [3:0] ST_READ = 4'h4;
  localparam [3:0] ST_WRITE = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [`ORX_OP_W-1:0] op_q;
  reg [`ORX_OP_W-1:0] op_d;
  reg [`ORX_PC_W-1:0] stack_q [0:`ORX_STACK_DEPTH-1];
  reg [`ORX_SP_W-1:0] sp_q;
  reg [`ORX_SP_W-1:0] sp_d;
  reg [`ORX_PC_W-1:0] pc_d;
  reg [`ORX_DATA_W-1:0] accumulator_d;
  reg zero_flag_d;
  reg master_interrupt_enable_d;
  reg mem_rd_d;
  reg mem_wr_d;
  reg [`ORX_ADDR_W-1:0] mem_addr_d;
  reg [`ORX_DATA_W-1:0] mem_wdata_d;
  reg int_taken_d;
  reg stack_push;
  reg [`ORX_PC_W-1:0] stack_push_pc;

  wire [`ORX_DATA_W-1:0] alu_b;
  wire alu_rotate;
  wire [`ORX_DATA_W-1:0] alu_y;
  wire alu_zero;
  wire is_mem_op;
  wire take_int;
  wire [`ORX_SP_W-1:0] sp_top;
  wire [`ORX_PC_W-1:0] pc_next;

  // one shared alu: in idle it serves or-immediate, in read the memory forms;
  // rotate is gated by the state so a stale opcode cannot bend an or-immediate
  assign alu_b = (state_q == ST_READ) ? mem_rdata : instr_imm;
  assign alu_rotate = (state_q == ST_READ) && (op_q == `ORX_OP_ROT_LEFT_MEM);
  orx_alu u_alu (
    .a(accumulator_q),
    .b(alu_b),
    .rotate(alu_rotate),
    .y(alu_y),
    .zero(alu_zero)
  );

  assign instr_ready = (state_q == ST_IDLE) && !take_int;
  assign is_mem_op = (instr_op == `ORX_OP_OR_MEM) || (instr_op == `ORX_OP_OR_INTO_MEM) ||
    (instr_op == `ORX_OP_ROT_LEFT_MEM);
  // interrupts are taken only between instructions, so an enable set by
  // the interrupt return lets a pending request in before the next fetch
  assign take_int = master_interrupt_enable_q && int_pending;
  assign sp_top = sp_q - 3'h1;
  assign pc_next = pc_q + 13'h0001;

  // next-state logic; registers hold unless a branch moves them, but the mem_rd_q, mem_wr_q and int_taken_q strobes default low
  always @* begin
    state_d = state_q;
    op_d = op_q;
    sp_d = sp_q;
    pc_d = pc_q;
    accumulator_d = accumulator_q;
    zero_flag_d = zero_flag_q;
    master_interrupt_enable_d = master_interrupt_enable_q;
    mem_rd_d = 1'b0;
    mem_wr_d = 1'b0;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    int_taken_d = 1'b0;
    stack_push = 1'b0;
    stack_push_pc = pc_q;
    case (state_q)
      ST_IDLE: begin
        if (take_int) begin
          // vector entry: push pc, mask further interrupts
          stack_push = 1'b1;
          stack_push_pc = pc_q;
          sp_d = sp_q + 3'h1;
          pc_d = `ORX_INT_VECTOR;
          master_interrupt_enable_d = 1'b0;
          int_taken_d = 1'b1;
        end else if (call_valid) begin
          stack_push = 1'b1;
          stack_push_pc = pc_next;
          sp_d = sp_q + 3'h1;
          pc_d = call_target;
        end else if (instr_valid) begin
          op_d = instr_op;
          if (is_mem_op) begin
            mem_rd_d = 1'b1;
            mem_addr_d = instr_addr;
            state_d = ST_WAIT;
          end else begin
            case (instr_op)
              `ORX_OP_OR_IMM: begin
                accumulator_d = alu_y;
                zero_flag_d = alu_zero;
                pc_d = pc_next;
              end
              `ORX_OP_RET: begin
                pc_d = stack_q[sp_top];
                sp_d = sp_top;
              end
              `ORX_OP_RET_VAL: begin
                pc_d = stack_q[sp_top];
                sp_d = sp_top;
                accumulator_d = instr_imm;
              end
              `ORX_OP_INT_RETURN: begin
                pc_d = stack_q[sp_top];
                sp_d = sp_top;
                master_interrupt_enable_d = 1'b1;
              end
              default: begin
                pc_d = pc_next;
              end
            endcase
          end
        end
      end
      ST_WAIT: begin
        // the read port is registered: its data stands only in the next cycle
        state_d = ST_READ;
      end
      ST_READ: begin
        pc_d = pc_next;
        if (op_q == `ORX_OP_OR_MEM) begin
          accumulator_d = alu_y;
          zero_flag_d = alu_zero;
          state_d = ST_IDLE;
        end else begin
          // or-into-memory and rotate write back; accumulator untouched
          mem_wr_d = 1'b1;
          mem_wdata_d = alu_y;
          if (op_q == `ORX_OP_OR_INTO_MEM) begin
            zero_flag_d = alu_zero;
          end
          state_d = ST_WRITE;
        end
      end
      ST_WRITE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // register stage
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      op_q <= `ORX_OP_NOP;
      sp_q <= 3'h0;
      pc_q <= `ORX_PC_RST;
      accumulator_q <= `ORX_ACC_RST;
      zero_flag_q <= 1'b0;
      master_interrupt_enable_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= 8'h00;
      mem_wdata_q <= 8'h00;
      int_taken_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      accumulator_q <= accumulator_d;
      zero_flag_q <= zero_flag_d;
      master_interrupt_enable_q <= master_interrupt_enable_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      mem_addr_q <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      int_taken_q <= int_taken_d;
    end
  end

  // the stack has no reset and wraps at its depth: nesting deeper than
  // eight overwrites the oldest return address without warning
  always @(posedge clk) begin
    if (!rst && stack_push) begin
      stack_q[sp_q] <= stack_push_pc;
    end
  end

endmodule // orx_exec

/* bench/orx_exec_assertions.sv */
// checker for orx_exec
// assumes a bind into orx_exec, one clock
`timescale 1ns/10ps
`include "orx_consts.vh"
module orx_exec_assertions (
  // in
  input wire clk,
  input wire rst,
  input wire instr_valid,
  input wire instr_ready,
  input wire call_valid,
  input wire int_pending,
  input wire [3:0] instr_op,
  input wire [7:0] instr_addr,
  input wire [7:0] instr_imm,
  input wire [7:0] mem_rdata,
  // out
  input wire mem_rd_q,
  input wire mem_wr_q,
  input wire [7:0] mem_addr_q,
  input wire [7:0] mem_wdata_q,
  input wire [7:0] accumulator_q,
  input wire zero_flag_q,
  input wire master_interrupt_enable_q,
  input wire [12:0] pc_q,
  input wire int_taken_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // 4'hF is no opcode, so it marks no take
  wire [3:0] op = (instr_valid && instr_ready && !call_valid) ? instr_op : 4'hF;
  a_nop_quiet: assert property (op == `ORX_OP_NOP |=> $stable(accumulator_q))
    else $error("nop");
  a_or_imm: assert property (op == `ORX_OP_OR_IMM |=> zero_flag_q == !accumulator_q
    && accumulator_q == ($past(accumulator_q) | $past(instr_imm))) else $error("ori");
  a_mem_read: assert property (op == `ORX_OP_OR_MEM |=> mem_rd_q
    && mem_addr_q == $past(instr_addr)) else $error("rd");
  a_orm_write: assert property (op == `ORX_OP_OR_INTO_MEM |-> ##3 mem_wr_q
    && mem_wdata_q == (accumulator_q | $past(mem_rdata))) else $error("orm");
  a_rot_write: assert property (op == `ORX_OP_ROT_LEFT_MEM |-> ##3 mem_wr_q
    && {mem_wdata_q[0], mem_wdata_q[7:1]} == $past(mem_rdata)) else $error("rot");
  a_ret_value: assert property (op == `ORX_OP_RET_VAL |=> $stable(zero_flag_q)
    && accumulator_q == $past(instr_imm)) else $error("retv");
  a_int_enable: assert property (op == `ORX_OP_INT_RETURN |=> master_interrupt_enable_q)
    else $error("en");
  a_pend_first: assert property (op == `ORX_OP_INT_RETURN ##1 int_pending |=> int_taken_q
    && pc_q == `ORX_INT_VECTOR) else $error("pend");
endmodule // orx_exec_assertions

/* bench/orx_mem_model.sv */
// data memory answering the cycle after a read strobe
// assumes the design's registered strobes
`timescale 1ns/10ps
module orx_mem_model (
  // in
  input wire clk,
  input wire mem_rd_q,
  input wire mem_wr_q,
  input wire [7:0] mem_addr_q,
  input wire [7:0] mem_wdata_q,
  // out
  output reg [7:0] mem_rdata = 8'h5A
);
  reg [7:0] mem [0:255];
  // toggles outside a read so a stale sample shows
  always @(posedge clk) begin
    mem_rdata <= mem_rd_q ? mem[mem_addr_q] : ~mem_rdata;
    if (mem_wr_q) mem[mem_addr_q] <= mem_wdata_q;
  end
endmodule // orx_mem_model

/* bench/orx_exec_tb.sv */
// bench for orx_exec
// assumes orx_mem_model as data memory
`timescale 1ns/10ps
`include "orx_consts.vh"
`define CHK(n,e,s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module orx_exec_tb;
  reg clk = 0, rst = 1, instr_valid = 0, call_valid = 0, int_pending = 0;
  reg [3:0] instr_op = 0;
  reg [7:0] instr_addr = 0, instr_imm = 0;
  reg [12:0] call_target = 0, p;
  wire instr_ready, mem_rd_q, mem_wr_q, zero_flag_q, master_interrupt_enable_q, int_taken_q;
  wire [7:0] mem_addr_q, mem_wdata_q, mem_rdata, accumulator_q;
  wire [12:0] pc_q;
  int miscompares = 0, num_checks = 0, cyc = 0;
  orx_exec i_orx_exec(
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_imm(instr_imm), .instr_ready(instr_ready),
    .call_valid(call_valid), .call_target(call_target), .int_pending(int_pending),
    .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .accumulator_q(accumulator_q),
    .zero_flag_q(zero_flag_q), .master_interrupt_enable_q(master_interrupt_enable_q),
    .pc_q(pc_q), .int_taken_q(int_taken_q)
  );
  orx_mem_model i_orx_mem_model(
    .clk(clk), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata)
  );
  task automatic run(input [3:0] o, input [7:0] a, input [7:0] x);
    @(negedge clk) {instr_op, instr_addr, instr_imm, instr_valid} = {o, a, x, 1'b1};
    while (instr_ready !== 1'b1) @(negedge clk);
    @(negedge clk) instr_valid = 0;
    repeat (5) @(negedge clk);
  endtask
  task automatic call(input [12:0] t);
    p = pc_q;
    @(negedge clk) {call_target, call_valid} = {t, 1'b1};
    @(negedge clk) call_valid = 0;
  endtask
  task t_or;
    i_orx_mem_model.mem[8'h10] = 8'h82;
    run(`ORX_OP_OR_IMM, 8'h00, 8'h00);
    `CHK("z", 1'b1, zero_flag_q)
    run(`ORX_OP_OR_IMM, 8'h00, 8'h41);
    `CHK("acc", 8'h41, accumulator_q)
    `CHK("z", 1'b0, zero_flag_q)
    run(`ORX_OP_OR_MEM, 8'h10, 8'h00);
    `CHK("acc", 8'hC3, accumulator_q)
    p = pc_q;
    run(`ORX_OP_NOP, 8'h00, 8'h00);
    `CHK("pc", p + 13'h1, pc_q)
  endtask
  task t_mem;
    i_orx_mem_model.mem[8'h20] = 8'h0C;
    i_orx_mem_model.mem[8'h30] = 8'h81;
    run(`ORX_OP_OR_INTO_MEM, 8'h20, 8'h00);
    `CHK("m", 8'hCF, i_orx_mem_model.mem[8'h20])
    `CHK("acc", 8'hC3, accumulator_q)
    run(`ORX_OP_ROT_LEFT_MEM, 8'h30, 8'h00);
    `CHK("m", 8'h03, i_orx_mem_model.mem[8'h30])
  endtask
  task t_ret;
    call(13'h0100);
    run(`ORX_OP_RET, 8'h00, 8'h00);
    `CHK("pc", p + 13'h1, pc_q)
    call(13'h0200);
    run(`ORX_OP_RET_VAL, 8'h00, 8'h00);
    `CHK("z", 1'b0, zero_flag_q)
    `CHK("acc", 8'h00, accumulator_q)
    `CHK("pc", p + 13'h1, pc_q)
    call(13'h0300);
    int_pending = 1;
    run(`ORX_OP_INT_RETURN, 8'h00, 8'h00);
    int_pending = 0;
    `CHK("pc", `ORX_INT_VECTOR, pc_q)
    call(13'h0400);
    run(`ORX_OP_INT_RETURN, 8'h00, 8'h00);
    `CHK("pc", p + 13'h1, pc_q)
    `CHK("en", 1'b1, master_interrupt_enable_q)
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  // a hang costs a mismatch, then the report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    t_or;
    t_mem;
    t_ret;
    tally_and_finish;
  end
endmodule // orx_exec_tb
bind orx_exec orx_exec_assertions i_orx_exec_assertions(
  .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .call_valid(call_valid), .int_pending(int_pending), .instr_op(instr_op),
  .instr_addr(instr_addr), .instr_imm(instr_imm), .mem_rdata(mem_rdata),
  .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q),
  .mem_wdata_q(mem_wdata_q), .accumulator_q(accumulator_q), .zero_flag_q(zero_flag_q),
  .master_interrupt_enable_q(master_interrupt_enable_q), .pc_q(pc_q),
  .int_taken_q(int_taken_q)
);
